/* File: cipher_bridge_checker_assertions.sv */
// pin-level checks for the cpu to cipher strobe bridge
// assumes upper strobe is held high by the cpu on legal accesses
`default_nettype none

module cipher_bridge_checker (
    // clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RESET,
    // cpu side
    input wire logic       CPU_ADDR_STROBE_N,
    input wire logic       UPPER_BYTE_STROBE_N,
    input wire logic [1:0] CPU_ADDR,
    // bridge outputs
    input wire logic       ACK_TOTEM_OUT_N,
    input wire logic       ACK_OPEN_DRAIN_OUT,
    input wire logic       ACK_OPEN_DRAIN_OE_N,
    input wire logic       PERIPH_ADDR_STROBE_N,
    input wire logic       PERIPH_DATA_STROBE_N,
    input wire logic       PERIPH_CHIP_SELECT_N,
    input wire logic       CIPHER_CLOCK
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    logic [5:0] still;  // cycles since the cipher clock moved
    logic       last;   // cipher clock one cycle ago
    // no saturation: the limit below fires at 60, four counts before the count wraps
    always_ff @(posedge SYS_CLK or posedge RESET)
        if (RESET)
        begin
            still <= 6'h00;
            last  <= 1'b0;
        end
        else
        begin
            still <= (CIPHER_CLOCK != last) ? 6'h00 : still + 6'h01;
            last  <= CIPHER_CLOCK;
        end
    property p_div; still < 6'h3C; endproperty
    a_div: assert property (p_div)
        else $error("cipher clock stopped");
    property p_latch; CPU_ADDR[1] [*8] |-> PERIPH_ADDR_STROBE_N; endproperty
    a_latch: assert property (p_latch)
        else $error("address strobe in data cycle");
    property p_upper; (!UPPER_BYTE_STROBE_N) [*8]
        |-> PERIPH_ADDR_STROBE_N && PERIPH_DATA_STROBE_N && ACK_OPEN_DRAIN_OE_N; endproperty
    a_upper: assert property (p_upper)
        else $error("upper lane access not refused");
    property p_pair; $fell(ACK_TOTEM_OUT_N) |-> !ACK_OPEN_DRAIN_OE_N && !ACK_OPEN_DRAIN_OUT;
    endproperty
    a_pair: assert property (p_pair)
        else $error("acknowledges not paired");
    property p_one; !PERIPH_ADDR_STROBE_N |-> PERIPH_DATA_STROBE_N; endproperty
    a_one: assert property (p_one)
        else $error("both strobes active");
    property p_cs; !PERIPH_CHIP_SELECT_N; endproperty
    a_cs: assert property (p_cs)
        else $error("chip select released");
    property p_release; $rose(CPU_ADDR_STROBE_N) |-> ##[1:14] ACK_TOTEM_OUT_N; endproperty
    a_release: assert property (p_release)
        else $error("ack held too long");
    property p_force; $fell(ACK_TOTEM_OUT_N) && !PERIPH_DATA_STROBE_N
        |-> ##[0:2] !CIPHER_CLOCK; endproperty
    a_force: assert property (p_force)
        else $error("cipher clock not forced low");
    property p_stretch; $fell(ACK_TOTEM_OUT_N) && !PERIPH_DATA_STROBE_N
        |-> ##3 (!CIPHER_CLOCK) [*8]; endproperty
    a_stretch: assert property (p_stretch)
        else $error("cipher clock low phase short");
    property p_idle; CPU_ADDR_STROBE_N [*8]
        |-> PERIPH_ADDR_STROBE_N && PERIPH_DATA_STROBE_N && ACK_OPEN_DRAIN_OE_N; endproperty
    a_idle: assert property (p_idle)
        else $error("outputs active while idle");
endmodule

bind cipher_strobe_bridge cipher_bridge_checker u_checker (.*);

`default_nettype wire

/* File: cipher_bridge_pkg.sv */
// types shared by the cpu to cipher strobe bridge
// assumes the constants header sits in the same folder
`default_nettype none

package cipher_bridge_pkg;

    // qualified cpu bus inputs after synchronisation
    typedef struct packed {
        logic addr_strobe;      // address strobe active
        logic select;           // decoded chip select active
        logic lower_strobe;     // lower byte strobe active
        logic upper_strobe;     // upper byte strobe active
        logic read;             // read not write
        logic addr_bit1;        // address bit 1
        logic addr_bit0;        // address bit 0
    } cpu_bus_t;

    // kind of access currently on the bus
    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_LATCH = 2'b01,
        ACC_READ  = 2'b10,
        ACC_WRITE = 2'b11
    } access_t;

    // peripheral strobe pair, active high inside the block
    typedef struct packed {
        logic addr_strobe;
        logic data_strobe;
    } periph_strobe_t;

endpackage

`default_nettype wire

/* File: cipher_bridge_regs.svh */
// timing constants and polarity values for the cpu to cipher strobe bridge
// assumes a single system clock; included by the clock generator and bridge modules
`ifndef CIPHER_BRIDGE_REGS_SVH
`define CIPHER_BRIDGE_REGS_SVH

// cpu clock rate that the cipher clock is derived from
`define CPU_CLK_MHZ          8
// cipher clock rate after division by two
`define CIPHER_CLK_MHZ       4
// cpu clock periods the cipher clock is held low after a data transfer
`define STRETCH_LOW_CYCLES   2
// bus state after which a write is acknowledged (one wait state)
`define WRITE_ACK_STATE      4
// bus state after which latch and read cycles are acknowledged
`define FAST_ACK_STATE       2
// address bit positions on the cpu address bus
`define ADDR_BIT_SELECT      1
`define ADDR_BIT_ODD         0
// reset levels of the active-low strobe and ack outputs and of the cipher clock
`define STROBE_IDLE          1'b1
`define CIPHER_CLK_RESET     1'b0

`endif

/* File: cipher_clock_gen.sv */
// cipher clock divider: cpu clock enable divided by two with a low stretch
// assumes cpu_tick marks each cpu clock falling edge, one cycle wide
`include "cipher_bridge_regs.svh"
`default_nettype none

module cipher_clock_gen
    import cipher_bridge_pkg::*;
#(
    parameter int STRETCH = `STRETCH_LOW_CYCLES
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // timing
    input  wire logic cpu_tick,
    input  wire logic force_low,
    // divided clock level
    output var  logic cipher_clock
);

    // low stretch counter in cpu clock periods
    logic [1:0] stretch_cnt;
    // counter is busy holding the clock low
    wire        stretching = (stretch_cnt != 2'h0);

    // the force is taken as a restart so the clock sits low for a full
    // stretch and the cipher chip sees a clean falling edge while the data strobe is active
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            cipher_clock <= `CIPHER_CLK_RESET;
            stretch_cnt  <= 2'h0;
        end
        else if (force_low)
        begin
            cipher_clock <= 1'b0;
            stretch_cnt  <= 2'(STRETCH);
        end
        else if (cpu_tick)
        begin
            if (stretching)
            begin
                cipher_clock <= 1'b0;
                stretch_cnt  <= stretch_cnt - 2'h1;
            end
            else
            begin
                cipher_clock <= ~cipher_clock;
            end
        end
    end

endmodule

`default_nettype wire

/* File: cipher_strobe_bridge.sv */
// cpu to cipher strobe bridge: strobes, acknowledges and cipher clock
// assumes the cpu bus pins arrive asynchronously and the cpu clock is
// an input pin sampled at the system clock rate
`include "cipher_bridge_regs.svh"
`default_nettype none

module cipher_strobe_bridge
    import cipher_bridge_pkg::*;
(
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET,
    // cpu clock pin
    input  wire logic CPU_CLK,
    // cpu bus control, active low pins
    input  wire logic CPU_ADDR_STROBE_N,
    input  wire logic SELECT_N,
    input  wire logic LOWER_BYTE_STROBE_N,
    input  wire logic UPPER_BYTE_STROBE_N,
    input  wire logic READ_NOT_WRITE,
    input  wire logic [1:0] CPU_ADDR,
    // acknowledges to the cpu
    output var  logic ACK_TOTEM_OUT_N,
    output var  logic ACK_OPEN_DRAIN_OUT,
    output var  logic ACK_OPEN_DRAIN_OE_N,
    // cipher chip master port
    output var  logic PERIPH_ADDR_STROBE_N,
    output var  logic PERIPH_DATA_STROBE_N,
    output var  logic PERIPH_CHIP_SELECT_N,
    output var  logic CIPHER_CLOCK
);

    // three-stage synchronisers for all pin inputs
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] pin_val;      // debounced: changes once stages agree

    assign pin_raw = {CPU_CLK, ~CPU_ADDR_STROBE_N, ~SELECT_N, ~LOWER_BYTE_STROBE_N,
                      ~UPPER_BYTE_STROBE_N, READ_NOT_WRITE, CPU_ADDR};

    // stage one feeds stage two only
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // each bit accepts a change only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_agree
            always_ff @(posedge SYS_CLK or posedge RESET)
            begin
                if (RESET)
                    pin_val[g] <= 1'b0;
                else if (sync2[g] == sync3[g])
                    pin_val[g] <= sync3[g];
            end
        end
    endgenerate

    // bus view after synchronisation
    cpu_bus_t bus;
    logic     cpu_clk_s;
    assign cpu_clk_s = pin_val[7];
    assign bus = '{addr_strobe:  pin_val[6], select: pin_val[5],
                   lower_strobe: pin_val[4], upper_strobe: pin_val[3],
                   read:         pin_val[2], addr_bit1: pin_val[1],
                   addr_bit0:    pin_val[0]};

    // cpu clock edge detection on the settled level
    logic cpu_clk_d;
    wire  cpu_rise = cpu_clk_s & ~cpu_clk_d;
    wire  cpu_fall = ~cpu_clk_s & cpu_clk_d;
    wire  cpu_edge = cpu_rise | cpu_fall;

    // classifies a bus cycle; used for both strobes and the ack
    function automatic access_t classify(input cpu_bus_t b);
        if (!(b.addr_strobe && b.select && b.lower_strobe && !b.upper_strobe))
            classify = ACC_IDLE;
        else if (!b.addr_bit1)
            classify = ACC_LATCH;
        else if (b.read)
            classify = ACC_READ;
        else
            classify = ACC_WRITE;
    endfunction

    // current access kind
    access_t access;
    assign access = classify(bus);

    // falling cpu edges counted since the address strobe went active;
    // the first falling edge closes state two, the second closes state four
    logic [2:0] fall_cnt;
    logic       ack;            // internal acknowledge level
    logic       ack_d;          // ack one cycle ago, for the rising detect

    // fall_cnt still holds the count before the falling edge being judged,
    // so the edge that closes a state is the one seen with one fewer counted
    // latch ack after state two
    wire ack_latch = (access == ACC_LATCH) && (fall_cnt >= 3'(`FAST_ACK_STATE / 2 - 1));
    wire ack_read  = (access == ACC_READ) && (fall_cnt >= 3'(`FAST_ACK_STATE / 2 - 1));
    wire ack_write = (access == ACC_WRITE) && (fall_cnt >= 3'(`WRITE_ACK_STATE / 2 - 1));
    wire ack_cond  = ack_latch | ack_read | ack_write;

    // ack is set on a falling cpu edge once the state count allows it
    wire next_ack_set = cpu_fall && ack_cond;
    // release on first edge after strobe
    wire next_ack_clr = cpu_edge && !bus.addr_strobe;

    // rising edge of the ack in a data cycle forces the cipher clock low
    wire data_cycle = (access == ACC_READ) || (access == ACC_WRITE);
    wire force_low  = ack && !ack_d && data_cycle;

    // edge history and state counter
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            cpu_clk_d <= 1'b0;
            fall_cnt  <= 3'h0;
            ack_d     <= 1'b0;
        end
        else
        begin
            cpu_clk_d <= cpu_clk_s;
            ack_d     <= ack;
            // count only while the strobe is held, saturating
            if (!bus.addr_strobe)
                fall_cnt <= 3'h0;
            else if (cpu_fall && fall_cnt != 3'h7)
                fall_cnt <= fall_cnt + 3'h1;
        end
    end

    // ack level; release takes priority since the strobe has gone
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            ack <= 1'b0;
        else if (next_ack_clr)
            ack <= 1'b0;
        else if (next_ack_set)
            ack <= 1'b1;
    end

    periph_strobe_t next_strobe;
    assign next_strobe.addr_strobe = (access == ACC_LATCH) && !bus.read;
    // data strobe for read and write
    assign next_strobe.data_strobe = data_cycle;

    // registered outputs; idle values hold while no access qualifies, except the totem ack, which follows ack until its release
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ACK_TOTEM_OUT_N      <= `STROBE_IDLE;
            ACK_OPEN_DRAIN_OUT   <= 1'b0;
            ACK_OPEN_DRAIN_OE_N  <= `STROBE_IDLE;
            PERIPH_ADDR_STROBE_N <= `STROBE_IDLE;
            PERIPH_DATA_STROBE_N <= `STROBE_IDLE;
            PERIPH_CHIP_SELECT_N <= 1'b0;
        end
        else
        begin
            ACK_TOTEM_OUT_N      <= ~ack;
            ACK_OPEN_DRAIN_OUT   <= 1'b0;
            ACK_OPEN_DRAIN_OE_N  <= ~(ack && bus.addr_strobe && bus.select);
            PERIPH_ADDR_STROBE_N <= ~next_strobe.addr_strobe;
            PERIPH_DATA_STROBE_N <= ~next_strobe.data_strobe;
            PERIPH_CHIP_SELECT_N <= 1'b0;
        end
    end

    // cipher clock: divider plus stretch, ticked on cpu falling edges
    cipher_clock_gen #(
        .STRETCH      (`STRETCH_LOW_CYCLES)
    ) u_clock (
        .sys_clk      (SYS_CLK),
        .reset        (RESET),
        .cpu_tick     (cpu_fall),
        .force_low    (force_low),
        .cipher_clock (CIPHER_CLOCK)
    );

    // two-cycle access relies on the cpu ordering latch then data
    // the odd address bit is assumed and not checked here

endmodule

`default_nettype wire

/* File: cpu_bus_model.sv */
// behavioural cpu: free-running cpu clock and byte accesses
// assumes the bench samples what this model reports after each access
`default_nettype none

module cpu_bus_model (
    // clock and answers
    input  wire logic       SYS_CLK,
    input  wire logic       ACK_TOTEM_OUT_N,
    input  wire logic       ACK_WIRE,
    input  wire logic       PERIPH_ADDR_STROBE_N,
    input  wire logic       PERIPH_DATA_STROBE_N,
    // cpu bus
    output var  logic       CPU_CLK,
    output var  logic       CPU_ADDR_STROBE_N,
    output var  logic       SELECT_N,
    output var  logic       LOWER_BYTE_STROBE_N,
    output var  logic       UPPER_BYTE_STROBE_N,
    output var  logic       READ_NOT_WRITE,
    output var  logic [1:0] CPU_ADDR
);
    timeunit 1ns;
    timeprecision 100ps;
    // cpu clock runs free, its edges falling on system clock falling edges, never on rising ones
    initial
    begin
        {CPU_CLK, READ_NOT_WRITE, CPU_ADDR} = 4'h0;
        {CPU_ADDR_STROBE_N, SELECT_N, LOWER_BYTE_STROBE_N, UPPER_BYTE_STROBE_N} = 4'hF;
        forever #60 CPU_CLK = ~CPU_CLK;
    end
    // one access started just after a cpu clock rise; n is 0 with no ack
    task automatic access(input logic a1, r, u, s, output int n, output logic sa, sd, so);
        int i;
        n = 0;
        {sa, sd, so} = 3'h0;
        @(posedge CPU_CLK);
        @(posedge SYS_CLK);
        CPU_ADDR <= {a1, 1'b1};
        READ_NOT_WRITE <= r;
        {SELECT_N, UPPER_BYTE_STROBE_N} <= {s, u};
        {CPU_ADDR_STROBE_N, LOWER_BYTE_STROBE_N} <= 2'h0;
        for (i = 1; i < 60 && n == 0; i++)
        begin
            @(posedge SYS_CLK);
            sa |= (PERIPH_ADDR_STROBE_N === 1'b0);
            sd |= (PERIPH_DATA_STROBE_N === 1'b0);
            so |= (ACK_WIRE === 1'b0);
            if (ACK_TOTEM_OUT_N === 1'b0)
                n = i;
        end
        // strobe goes high between the two cycles
        {CPU_ADDR_STROBE_N, LOWER_BYTE_STROBE_N, UPPER_BYTE_STROBE_N, SELECT_N} <= 4'hF;
        CPU_ADDR <= ~{a1, 1'b1};
        READ_NOT_WRITE <= ~r;
        repeat (30) @(posedge SYS_CLK);
    endtask
endmodule

`default_nettype wire

/* File: cpu_to_cipher_strobe_bridge_test.sv */
// bench for the cpu to cipher strobe bridge with a behavioural cpu
// assumes the checker is bound to the bridge
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("FAIL %s expected %0h seen %0h", what, exp, got); end end

module cpu_to_cipher_strobe_bridge_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic       SYS_CLK, RESET, CPU_CLK, CPU_ADDR_STROBE_N, SELECT_N;
    logic       LOWER_BYTE_STROBE_N, UPPER_BYTE_STROBE_N, READ_NOT_WRITE;
    logic [1:0] CPU_ADDR;
    logic       ACK_TOTEM_OUT_N, ACK_OPEN_DRAIN_OUT, ACK_OPEN_DRAIN_OE_N, CIPHER_CLOCK;
    logic       PERIPH_ADDR_STROBE_N, PERIPH_DATA_STROBE_N, PERIPH_CHIP_SELECT_N;
    // pulled-up acknowledge wire seen by the cpu
    wire logic  ACK_WIRE = ACK_OPEN_DRAIN_OE_N ? 1'b1 : ACK_OPEN_DRAIN_OUT;
    int         err_count = 0;
    int         comparisons = 0;
    int         n;
    logic       sa, sd, so;
    cipher_strobe_bridge dut (.*);
    cpu_bus_model cpu (.*);
    initial
    begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (100000) @(posedge SYS_CLK);
        err_count++;
        finish_test;
    end
    task t_reset;
        `CHK("chip select", 1'b0, PERIPH_CHIP_SELECT_N)
        `CHK("ack idle", 2'h3, {ACK_TOTEM_OUT_N, ACK_OPEN_DRAIN_OE_N})
    endtask
    // ten half periods of the cipher clock in 120 cycles (cpu period 12 cycles)
    task t_divide;
        int i, t;
        logic p;
        t = 0;
        p = CIPHER_CLOCK;
        for (i = 0; i < 120; i++)
        begin
            @(posedge SYS_CLK);
            t += (CIPHER_CLOCK !== p);
            p = CIPHER_CLOCK;
        end
        `CHK("cipher toggles", 1'b1, t >= 9 && t <= 11)
    endtask
    // a1, read, ack window low and high, expected strobes
    task t_cycle(input logic a1, r, input int lo, hi, input logic ea, ed);
        cpu.access(a1, r, 1'b1, 1'b0, n, sa, sd, so);
        `CHK("ack delay", 1'b1, n >= lo && n <= hi)
        `CHK("strobes", {ea, ed}, {sa, sd})
        `CHK("open drain ack", 1'b1, so)
    endtask
    task t_refuse(input logic u, s);
        cpu.access(1'b1, 1'b0, u, s, n, sa, sd, so);
        `CHK("refused", 4'h0, {n == 0 ? 1'b0 : 1'b1, sa, sd, so})
    endtask
    initial
    begin
        RESET = 1'b1;
        repeat (20) @(posedge SYS_CLK);
        t_reset;
        RESET <= 1'b0;
        repeat (10) @(posedge SYS_CLK);
        t_divide;
        // latch, write with one wait, latch, read without wait
        t_cycle(1'b0, 1'b0, 6, 16, 1'b1, 1'b0);
        t_cycle(1'b1, 1'b0, 18, 28, 1'b0, 1'b1);
        t_cycle(1'b0, 1'b0, 6, 16, 1'b1, 1'b0);
        t_cycle(1'b1, 1'b1, 6, 16, 1'b0, 1'b1);
        t_refuse(1'b0, 1'b0);
        t_refuse(1'b1, 1'b1);
        finish_test;
    end
endmodule

`default_nettype wire
